// [ssy_pkg.sv]
// Purpose: Shared constants for the software error syndrome record
// Assumes: APB register access, 32-bit data
// Notes:   Bank stride and control offsets are fixed here
package ssy_pkg;
  // Syndrome codes
  localparam logic [7:0] SYN_ILLEGAL_BUS   = 8'h00;
  localparam logic [7:0] SYN_UNIT_DOWN     = 8'h01;
  localparam logic [7:0] SYN_PWR_REJECT    = 8'h02;
  localparam logic [7:0] SYN_PROP_CONFLICT = 8'h04;
  localparam logic [7:0] SYN_PEND_CONFLICT = 8'h05;
  localparam logic [7:0] SYN_WAKE_ABANDON  = 8'h07;
  localparam logic [7:0] SYN_SLEEP_FAILED  = 8'h08;
  localparam logic [7:0] SYN_GRP_ON_SLEEP  = 8'h09;
  localparam logic [7:0] SYN_SOFT_NO_TGT   = 8'h10;
  localparam logic [7:0] SYN_SOFT_CORRUPT  = 8'h11;
  localparam logic [7:0] SYN_PERCORE_CORR  = 8'h12;
  localparam logic [7:0] SYN_DIST_CORR     = 8'h13;
  localparam logic [7:0] SYN_XLATE_OFF     = 8'h14;
  localparam logic [7:0] SYN_BLOCK_MISSING = 8'h18;
  localparam logic [7:0] SYN_ID_RANGE      = 8'h19;
  localparam logic [7:0] SYN_SHARED_NO_TGT = 8'h1A;
  localparam logic [7:0] SYN_ONE_OF_N      = 8'h1B;
  localparam logic [7:0] SYN_COLLATOR      = 8'h1C;
  localparam logic [7:0] SYN_BAD_DEACT     = 8'h1D;
  localparam logic [7:0] SYN_OFFLINE_CHIP  = 8'h1E;
  // Error type codes
  localparam logic [7:0] ETYPE_CORRUPT  = 8'h06;
  localparam logic [7:0] ETYPE_ILLEGAL  = 8'h0E;
  localparam logic [7:0] ETYPE_PROGRAM  = 8'h0F;
  // Register map
  localparam logic [7:0] BANK_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MISC    = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
  localparam logic [7:0] OFS_CTRL    = 8'h20;
  // Status, address-high and control fields
  localparam int STAT_VALID_BIT  = 31;
  localparam int STAT_ADDRV_BIT  = 30;
  localparam int STAT_OVF_BIT    = 29;
  localparam int STAT_SYN_LSB    = 8;
  localparam int STAT_ETYPE_LSB  = 0;
  localparam int ADDR_HI_NS_BIT  = 31;
  localparam int CTRL_LOST_BIT   = 0;
  localparam int CTRL_MVIEW_BIT  = 1;
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// [ssy_log_if.sv]
// Purpose: Carries one log request to the encoder and its packed result
// Assumes: Encoder is purely combinational
// Notes:   src drives the request, enc answers
interface ssy_log_if;
  logic [7:0]  syn;
  logic [8:0]  core;
  logic [8:0]  unit;
  logic [9:0]  id;
  logic [4:0]  block;
  logic        rnw;
  logic        sparse;
  logic [2:0]  size;
  logic [7:0]  len;
  logic [7:0]  etype;
  logic [31:0] data;
  logic        known;
  logic        bank_zero;
  logic        uses_addr;
  modport src (output syn, core, unit, id, block, rnw, sparse, size, len,
               input  etype, data, known, bank_zero, uses_addr);
  modport enc (input  syn, core, unit, id, block, rnw, sparse, size, len,
               output etype, data, known, bank_zero, uses_addr);
endinterface

// [ssy_encoder.sv]
// Purpose: Maps a syndrome to its error type, packed data and bank choice
// Assumes: Unknown codes are flagged and not logged
// Notes:   Undefined data bits are zero
module ssy_encoder (
  ssy_log_if.enc lg
);
  always_comb begin
    lg.etype     = 8'h00;
    lg.data      = 32'h0000_0000;
    lg.known     = 1'b1;
    lg.bank_zero = 1'b0;
    lg.uses_addr = 1'b0;
    unique case (lg.syn)
      ssy_pkg::SYN_ILLEGAL_BUS: begin
        lg.etype = ssy_pkg::ETYPE_ILLEGAL;
        lg.data  = {19'h0, lg.rnw, lg.sparse, lg.size, lg.len};
      end
      ssy_pkg::SYN_UNIT_DOWN, ssy_pkg::SYN_PWR_REJECT: begin
        lg.etype     = ssy_pkg::ETYPE_PROGRAM;
        lg.data      = {7'h0, lg.unit, 7'h0, lg.core};
        lg.bank_zero = 1'b1;
      end
      ssy_pkg::SYN_PROP_CONFLICT, ssy_pkg::SYN_PEND_CONFLICT,
      ssy_pkg::SYN_WAKE_ABANDON, ssy_pkg::SYN_GRP_ON_SLEEP: begin
        lg.etype = ssy_pkg::ETYPE_PROGRAM;
        lg.data  = {23'h0, lg.core};
      end
      ssy_pkg::SYN_SLEEP_FAILED: begin
        lg.etype     = ssy_pkg::ETYPE_PROGRAM;
        lg.data      = {23'h0, lg.core};
        lg.bank_zero = 1'b1;
      end
      ssy_pkg::SYN_SOFT_NO_TGT: begin
        lg.etype = ssy_pkg::ETYPE_ILLEGAL;
        lg.data  = {23'h0, lg.core};
      end
      ssy_pkg::SYN_SOFT_CORRUPT: begin
        lg.etype     = ssy_pkg::ETYPE_CORRUPT;
        lg.data      = {23'h0, lg.core};
        lg.bank_zero = 1'b1;
      end
      ssy_pkg::SYN_PERCORE_CORR: begin
        lg.etype     = ssy_pkg::ETYPE_CORRUPT;
        lg.uses_addr = 1'b1;
      end
      ssy_pkg::SYN_DIST_CORR: begin
        lg.etype     = ssy_pkg::ETYPE_CORRUPT;
        lg.uses_addr = 1'b1;
        lg.bank_zero = 1'b1;
      end
      ssy_pkg::SYN_XLATE_OFF: begin
        lg.etype     = ssy_pkg::ETYPE_PROGRAM;
        lg.uses_addr = 1'b1;
      end
      ssy_pkg::SYN_BLOCK_MISSING: begin
        lg.etype = ssy_pkg::ETYPE_ILLEGAL;
        lg.data  = {27'h0, lg.block};
      end
      ssy_pkg::SYN_ID_RANGE: begin
        lg.etype = ssy_pkg::ETYPE_ILLEGAL;
        lg.data  = {22'h0, lg.id};
      end
      ssy_pkg::SYN_SHARED_NO_TGT, ssy_pkg::SYN_ONE_OF_N,
      ssy_pkg::SYN_OFFLINE_CHIP: begin
        lg.etype = ssy_pkg::ETYPE_PROGRAM;
        lg.data  = {22'h0, lg.id};
      end
      ssy_pkg::SYN_COLLATOR: begin
        lg.etype     = ssy_pkg::ETYPE_PROGRAM;
        lg.data      = {22'h0, lg.id};
        lg.bank_zero = 1'b1;
      end
      ssy_pkg::SYN_BAD_DEACT: begin
        lg.etype = ssy_pkg::ETYPE_ILLEGAL;
      end
      default: begin
        lg.known = 1'b0;
      end
    endcase
  end
endmodule

// [ssy_base_guard.sv]
// Purpose: Holds one table base and refuses conflicting reprogramming
// Assumes: in_use marks the current base as live
// Notes:   refused_q pulses one cycle per refused write
module ssy_base_guard #(
  parameter int W = 52
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr_req,
  input  wire logic [W-1:0] wr_val,
  input  wire logic         in_use,
  output logic      [W-1:0] base_q,
  output logic              refused_q
);
  logic conflict;
  assign conflict = in_use && (wr_val != base_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      base_q <= '0;
    end else if (wr_req && !conflict) begin
      base_q <= wr_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= wr_req && conflict;
    end
  end
endmodule

// [ssy_syndrome_rec.sv]
// Purpose: Software error record with two view banks behind APB
// Assumes: Event inputs are single-cycle pulses on clk
// Notes:   A full bank keeps its first entry and flags overflow
//
// What this block does
// - Illegal bus access: code 0x0, access fields
// - Powered-down unit access: 0x1, unit, core
// - Rejected power-down: 0x2, unit, core
// - Property base conflict refused, logs 0x4
// - Pending base conflict refused, logs 0x5
// - Sleep with group enables logs 0x9
// - Soft interrupt without target logs 0x10
// - Corrupted soft interrupt logs 0x11, bank 0
// - Corrupt register reads log 0x12/0x13, address
// - Powered-down translator read logs 0x14, address
// - Missing shared block logs 0x18, block
// - Bad doorbell identifier logs 0x19, identifier
// - Shared interrupt without target logs 0x1A
// - Undeliverable one-of-N logs 0x1B
// - Collator out of range logs 0x1C
// - Send to offline chip logs 0x1E
// - Data packed from bit 0, rest zero
// - Per-view banks only with multi-view support
// - Address register gated by code and valid
module ssy_syndrome_rec #(
  parameter int AW = 8,
  parameter int BW = 52
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          multi_view_support_flag,
  input  wire logic          log_valid,
  input  wire logic [7:0]    log_syn,
  input  wire logic [8:0]    log_core,
  input  wire logic [8:0]    log_unit,
  input  wire logic [9:0]    log_id,
  input  wire logic [4:0]    log_block,
  input  wire logic          access_read_not_write,
  input  wire logic          access_sparse_flag,
  input  wire logic [2:0]    access_size_field,
  input  wire logic [7:0]    access_length_field,
  input  wire logic          log_view,
  input  wire logic          log_deact_private,
  input  wire logic [51:0]   log_addr,
  input  wire logic          log_addr_ns,
  input  wire logic          prop_wr,
  input  wire logic          pend_wr,
  input  wire logic [BW-1:0] base_wr_val,
  input  wire logic [8:0]    base_wr_core,
  input  wire logic          base_wr_view,
  input  wire logic          prop_in_use,
  input  wire logic          pend_in_use,
  output logic      [BW-1:0] property_table_base,
  output logic      [BW-1:0] pending_table_base
);
  localparam int NB = 2;

  ssy_log_if lg ();

  logic       prop_ref;
  logic       pend_ref;
  logic [8:0] ref_core_q;
  logic       ref_view_q;

  ssy_base_guard #(.W(BW)) u_prop (
    .clk       (clk),
    .rst       (rst),
    .wr_req    (prop_wr),
    .wr_val    (base_wr_val),
    .in_use    (prop_in_use),
    .base_q    (property_table_base),
    .refused_q (prop_ref)
  );

  ssy_base_guard #(.W(BW)) u_pend (
    .clk       (clk),
    .rst       (rst),
    .wr_req    (pend_wr),
    .wr_val    (base_wr_val),
    .in_use    (pend_in_use),
    .base_q    (pending_table_base),
    .refused_q (pend_ref)
  );

  ssy_encoder u_enc (
    .lg (lg)
  );

  // Core and view of the refused base write
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_core_q <= 9'h000;
      ref_view_q <= 1'b0;
    end else if (prop_wr || pend_wr) begin
      ref_core_q <= base_wr_core;
      ref_view_q <= base_wr_view;
    end
  end

  // Source selection: refusals first, then external events
  logic ext_ok;
  logic ev_any;
  logic ev_view;
  logic lost_now;
  assign ext_ok = log_valid && !(log_syn == ssy_pkg::SYN_BAD_DEACT
                                 && log_deact_private);
  assign ev_any = prop_ref || pend_ref || ext_ok;
  assign lost_now = (prop_ref && pend_ref) || ((prop_ref || pend_ref) && ext_ok);

  always_comb begin
    lg.syn    = log_syn;
    lg.core   = log_core;
    lg.unit   = log_unit;
    lg.id     = log_id;
    lg.block  = log_block;
    lg.rnw    = access_read_not_write;
    lg.sparse = access_sparse_flag;
    lg.size   = access_size_field;
    lg.len    = access_length_field;
    ev_view   = log_view;
    if (prop_ref) begin
      lg.syn  = ssy_pkg::SYN_PROP_CONFLICT;
      lg.core = ref_core_q;
      ev_view = ref_view_q;
    end else if (pend_ref) begin
      lg.syn  = ssy_pkg::SYN_PEND_CONFLICT;
      lg.core = ref_core_q;
      ev_view = ref_view_q;
    end
  end

  // Strap pin through three stages; taken once the last two agree
  logic [2:0] mv_sync_q;
  logic       mview_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      mv_sync_q <= 3'h0;
    end else begin
      mv_sync_q <= {mv_sync_q[1:0], multi_view_support_flag};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mview_q <= 1'b0;
    end else if (mv_sync_q[2] == mv_sync_q[1]) begin
      mview_q <= mv_sync_q[2];
    end
  end

  logic ev_fire;
  logic ev_bank;
  assign ev_fire = ev_any && lg.known;
  assign ev_bank = mview_q && !lg.bank_zero && ev_view;

  // APB decode
  logic          acc;
  logic          wr_en;
  logic [AW-1:0] ofs;
  logic          bank_hit;
  logic          bank_idx;
  logic          ctrl_hit;
  assign acc      = psel && penable && pready;
  assign wr_en    = acc && pwrite;
  assign bank_hit = paddr < AW'(2 * ssy_pkg::BANK_STRIDE) && paddr[1:0] == 2'h0;
  assign bank_idx = paddr[4];
  assign ofs      = paddr & AW'(8'h0C);
  assign ctrl_hit = paddr == AW'(ssy_pkg::OFS_CTRL);

  // Per-bank record
  logic [NB-1:0]       v_q;
  logic [NB-1:0]       addrv_q;
  logic [NB-1:0]       ovf_q;
  logic [NB-1:0]       ns_q;
  logic [7:0]          syn_q   [NB];
  logic [7:0]          etype_q [NB];
  logic [31:0]         misc_q  [NB];
  logic [51:0]         addr_q  [NB];
  logic [NB-1:0]       addr_open;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      logic sel_w;
      logic hit_ev;
      logic clr_v;
      logic clr_o;
      assign sel_w  = wr_en && bank_hit && (bank_idx == 1'(b));
      assign hit_ev = ev_fire && (ev_bank == 1'(b));
      assign clr_v  = sel_w && ofs == AW'(ssy_pkg::OFS_STATUS)
                      && pwdata[ssy_pkg::STAT_VALID_BIT];
      assign clr_o  = sel_w && ofs == AW'(ssy_pkg::OFS_STATUS)
                      && pwdata[ssy_pkg::STAT_OVF_BIT];
      assign addr_open[b] = !addrv_q[b] && (syn_q[b] == ssy_pkg::SYN_ILLEGAL_BUS
                            || syn_q[b] == ssy_pkg::SYN_PERCORE_CORR
                            || syn_q[b] == ssy_pkg::SYN_DIST_CORR
                            || syn_q[b] == ssy_pkg::SYN_XLATE_OFF);

      // Record load: new entry wins over a same-cycle clear
      always_ff @(posedge clk) begin
        if (rst) begin
          v_q[b]     <= 1'b0;
          addrv_q[b] <= 1'b0;
          syn_q[b]   <= 8'h00;
          etype_q[b] <= 8'h00;
          misc_q[b]  <= 32'h0000_0000;
        end else if (hit_ev && (!v_q[b] || clr_v)) begin
          v_q[b]     <= 1'b1;
          addrv_q[b] <= lg.uses_addr;
          syn_q[b]   <= lg.syn;
          etype_q[b] <= lg.etype;
          misc_q[b]  <= lg.data;
        end else if (clr_v) begin
          v_q[b]     <= 1'b0;
          addrv_q[b] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          ovf_q[b] <= 1'b0;
        end else if (hit_ev && v_q[b] && !clr_v) begin
          ovf_q[b] <= 1'b1;
        end else if (clr_o) begin
          ovf_q[b] <= 1'b0;
        end
      end

      // Address register: event fill or gated software write
      always_ff @(posedge clk) begin
        if (rst) begin
          addr_q[b] <= 52'h0_0000_0000_0000;
          ns_q[b]   <= 1'b0;
        end else if (hit_ev && (!v_q[b] || clr_v)) begin
          addr_q[b] <= lg.uses_addr ? log_addr : 52'h0_0000_0000_0000;
          ns_q[b]   <= lg.uses_addr && log_addr_ns;
        end else if (sel_w && addr_open[b]) begin
          if (ofs == AW'(ssy_pkg::OFS_ADDR_LO)) begin
            addr_q[b][31:0] <= pwdata;
          end else if (ofs == AW'(ssy_pkg::OFS_ADDR_HI)) begin
            addr_q[b][51:32] <= pwdata[19:0];
            ns_q[b]          <= pwdata[ssy_pkg::ADDR_HI_NS_BIT];
          end
        end
      end
    end
  endgenerate

  // Lost-event flag, set wins over clear
  logic lost_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      lost_q <= 1'b0;
    end else if (lost_now) begin
      lost_q <= 1'b1;
    end else if (wr_en && ctrl_hit && pwdata[ssy_pkg::CTRL_LOST_BIT]) begin
      lost_q <= 1'b0;
    end
  end

  // Read mux
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = ssy_pkg::RESET_WORD;
    err_d = 1'b0;
    if (bank_hit) begin
      unique case (ofs)
        AW'(ssy_pkg::OFS_STATUS): begin
          rd_d[ssy_pkg::STAT_VALID_BIT] = v_q[bank_idx];
          rd_d[ssy_pkg::STAT_ADDRV_BIT] = addrv_q[bank_idx];
          rd_d[ssy_pkg::STAT_OVF_BIT]   = ovf_q[bank_idx];
          rd_d[ssy_pkg::STAT_SYN_LSB +: 8]   = syn_q[bank_idx];
          rd_d[ssy_pkg::STAT_ETYPE_LSB +: 8] = etype_q[bank_idx];
        end
        AW'(ssy_pkg::OFS_MISC): begin
          rd_d = misc_q[bank_idx];
        end
        AW'(ssy_pkg::OFS_ADDR_LO): begin
          if (addr_open[bank_idx] || addrv_q[bank_idx]) begin
            rd_d = addr_q[bank_idx][31:0];
          end
        end
        default: begin
          if (addr_open[bank_idx] || addrv_q[bank_idx]) begin
            rd_d[19:0] = addr_q[bank_idx][51:32];
            rd_d[ssy_pkg::ADDR_HI_NS_BIT] = ns_q[bank_idx];
          end
        end
      endcase
    end else if (ctrl_hit) begin
      rd_d[ssy_pkg::CTRL_LOST_BIT]  = lost_q;
      rd_d[ssy_pkg::CTRL_MVIEW_BIT] = mview_q;
    end else begin
      err_d = 1'b1;
    end
  end

  // APB answer: one wait state
  logic take;
  assign take = psel && penable && !pready;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= take;
    end
  end

  // Read data stands only in the answer cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (take && !pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // Error pulse rides with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= take && err_d;
    end
  end
endmodule

// [ssy_syndrome_rec_asserts.sv]
// Purpose: Port-level checks of the software error record
// Assumes: APB master keeps setup plus access phases
// Notes:   Bound to every ssy_syndrome_rec instance
module ssy_syndrome_rec_asserts #(
  parameter int AW = 8,
  parameter int BW = 52
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          multi_view_support_flag,
  input wire logic          prop_wr,
  input wire logic          pend_wr,
  input wire logic [BW-1:0] base_wr_val,
  input wire logic          prop_in_use,
  input wire logic          pend_in_use,
  input wire logic [BW-1:0] property_table_base,
  input wire logic [BW-1:0] pending_table_base
);
  function automatic logic [7:0] etype_of(input logic [7:0] code);
    case (code)
      8'h00, 8'h10, 8'h18, 8'h19, 8'h1D: return 8'h0E;
      8'h11, 8'h12, 8'h13: return 8'h06;
      default: return 8'h0F;
    endcase
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  access_ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered next cycle");
  slverr_map_a: assert property (pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  rdata_idle_a: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  reset_clear_a: assert property ($fell(rst) |-> !pready && property_table_base == '0
                                  && pending_table_base == '0)
    else $error("outputs not cleared by reset");
  prop_accept_a: assert property (
    prop_wr && !prop_in_use |=> property_table_base == $past(base_wr_val))
    else $error("free property base write not taken");
  pend_accept_a: assert property (
    pend_wr && !pend_in_use |=> pending_table_base == $past(base_wr_val))
    else $error("free pending base write not taken");
  prop_refuse_a: assert property (
    prop_wr && prop_in_use && base_wr_val != property_table_base |=> $stable(property_table_base))
    else $error("conflicting property base accepted");
  pend_refuse_a: assert property (
    pend_wr && pend_in_use && base_wr_val != pending_table_base |=> $stable(pending_table_base))
    else $error("conflicting pending base accepted");
  prop_hold_a: assert property (
    $changed(property_table_base) |-> $past(prop_wr) || $past(rst))
    else $error("property base changed without a write");
  ctrl_view_a: assert property (
    pready && !pwrite && paddr == 8'h20 |-> prdata[31:1] == {30'h0, multi_view_support_flag})
    else $error("control word does not show view strap");
  etype_match_a: assert property (
    pready && !pwrite && !pslverr && paddr < 8'h20 && paddr[3:0] == 4'h0 && prdata[31]
    |-> prdata[7:0] == etype_of(prdata[15:8]))
    else $error("error type does not match logged code");
endmodule

bind ssy_syndrome_rec ssy_syndrome_rec_asserts #(.AW(AW), .BW(BW)) u_chk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .multi_view_support_flag, .prop_wr, .pend_wr, .base_wr_val, .prop_in_use,
  .pend_in_use, .property_table_base, .pending_table_base);

// [tb_software_error_syndrome.sv]
// Purpose: Self-checking bench for the software error record
// Assumes: Random fields from a fixed xorshift seed
// Notes:   Every external code logged in single and multi view mode; 0x4/0x5 logged in multi view mode only
`define CHK(nm, x, g) begin n_tests++; if ((g) !== (x)) begin failures++; \
  $display("unexpected %s expected %h seen %h", nm, x, g); end end
module tb_software_error_syndrome;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, log_syn = 8'h00, access_length_field = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h89BF2D49;
  logic        pready, pslverr, multi_view_support_flag = 1'b0, log_valid = 1'b0;
  logic        access_read_not_write = 1'b0, access_sparse_flag = 1'b0, log_view = 1'b0;
  logic        log_deact_private = 1'b0, log_addr_ns = 1'b0, prop_wr = 1'b0, pend_wr = 1'b0;
  logic        base_wr_view = 1'b0, prop_in_use = 1'b0, pend_in_use = 1'b0;
  logic [8:0]  log_core = 9'h000, log_unit = 9'h000, base_wr_core = 9'h000;
  logic [9:0]  log_id = 10'h000;
  logic [4:0]  log_block = 5'h00;
  logic [2:0]  access_size_field = 3'h0;
  logic [51:0] log_addr = 52'h0, base_wr_val = 52'h0, property_table_base, pending_table_base;
  int          failures = 0, n_tests = 0;
  logic [7:0]  codes [18] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12,
                            8'h13, 8'h14, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E};

  ssy_syndrome_rec u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .multi_view_support_flag, .log_valid, .log_syn, .log_core, .log_unit,
    .log_id, .log_block, .access_read_not_write, .access_sparse_flag, .access_size_field,
    .access_length_field, .log_view, .log_deact_private, .log_addr, .log_addr_ns, .prop_wr,
    .pend_wr, .base_wr_val, .base_wr_core, .base_wr_view, .prop_in_use, .pend_in_use,
    .property_table_base, .pending_table_base);

  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] et(input logic [7:0] s);
    case (s)
      8'h00, 8'h10, 8'h18, 8'h19, 8'h1D: return 8'h0E;
      8'h11, 8'h12, 8'h13: return 8'h06;
      default: return 8'h0F;
    endcase
  endfunction

  function automatic logic bk(input logic [7:0] s, input logic v);
    if (!multi_view_support_flag || s inside {8'h01, 8'h02, 8'h08, 8'h11, 8'h13, 8'h1C})
      return 1'b0;
    return v;
  endfunction

  function automatic logic [31:0] st(input logic [7:0] s, input logic ovf);
    return {1'b1, s inside {8'h12, 8'h13, 8'h14}, ovf, 13'h0, s, et(s)};
  endfunction

  function automatic logic [31:0] md(input logic [7:0] s);
    case (s)
      8'h00: return {19'h0, access_read_not_write, access_sparse_flag, access_size_field,
                     access_length_field};
      8'h01, 8'h02: return {7'h0, log_unit, 7'h0, log_core};
      8'h07, 8'h08, 8'h09, 8'h10, 8'h11: return {23'h0, log_core};
      8'h18: return {27'h0, log_block};
      8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E: return {22'h0, log_id};
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      results();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(nm, x, r)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic vz(input logic b, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {3'h0, b, 4'h0}, 32'h0000_0000, r, e);
    `CHK(nm, 1'b0, r[31])
  endtask

  task automatic clr();
    wr(8'h00, 32'hA000_0000);
    wr(8'h10, 32'hA000_0000);
    wr(8'h20, 32'h0000_0001);
  endtask

  task automatic ev(input logic [7:0] s, input logic p);
    logic [31:0] r;
    logic [31:0] q;
    r = rnd();
    q = rnd();
    log_valid <= 1'b1;
    log_syn <= s;
    log_deact_private <= p;
    log_core <= r[8:0];
    log_unit <= r[17:9];
    log_id <= r[27:18];
    log_block <= q[4:0];
    access_read_not_write <= q[5];
    access_sparse_flag <= q[6];
    access_size_field <= q[9:7];
    access_length_field <= q[17:10];
    log_view <= q[18];
    log_addr_ns <= q[19];
    log_addr <= {q[31:12], r};
    @(posedge clk);
    log_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic base_case(input logic p);
    logic [51:0] v;
    logic [31:0] a;
    logic        b;
    a = rnd();
    v = {a[19:0], rnd()};
    clr();
    prop_wr <= !p;
    pend_wr <= p;
    base_wr_val <= v;
    prop_in_use <= 1'b0;
    pend_in_use <= 1'b0;
    @(posedge clk);
    prop_wr <= 1'b0;
    pend_wr <= 1'b0;
    @(posedge clk);
    `CHK("new base", v, p ? pending_table_base : property_table_base)
    prop_wr <= !p;
    pend_wr <= p;
    base_wr_val <= ~v;
    base_wr_core <= a[28:20];
    base_wr_view <= a[29];
    prop_in_use <= 1'b1;
    pend_in_use <= 1'b1;
    @(posedge clk);
    prop_wr <= 1'b0;
    pend_wr <= 1'b0;
    log_valid <= p;
    log_syn <= 8'h09;
    @(posedge clk);
    log_valid <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("kept base", v, p ? pending_table_base : property_table_base)
    b = bk(8'h04, base_wr_view);
    rd({3'h0, b, 4'h0}, st(p ? 8'h05 : 8'h04, 1'b0), "base status");
    rd({3'h0, b, 4'h4}, {23'h0, base_wr_core}, "base core");
    rd(8'h20, {30'h0, multi_view_support_flag, p}, "lost flag");
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    logic        b;
    logic        ad;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      multi_view_support_flag <= m[0];
      repeat (4) @(posedge clk);
      rd(8'h20, {30'h0, m[0], 1'b0}, "control");
      foreach (codes[i]) begin
        clr();
        ev(codes[i], 1'b0);
        b = bk(codes[i], log_view);
        ad = codes[i] inside {8'h12, 8'h13, 8'h14};
        rd({3'h0, b, 4'h0}, st(codes[i], 1'b0), "status");
        rd({3'h0, b, 4'h4}, md(codes[i]), "misc");
        vz(!b, "other bank");
        if (codes[i] != 8'h00) begin
          wr({3'h0, b, 4'h8}, rnd());
          rd({3'h0, b, 4'h8}, ad ? log_addr[31:0] : 32'h0000_0000, "addr low");
          rd({3'h0, b, 4'hC}, ad ? {log_addr_ns, 11'h0, log_addr[51:32]} : 32'h0000_0000,
             "addr high");
        end
      end
      $display("test codes view mode %0d done", m);
    end
    clr();
    ev(8'h1D, 1'b1);
    vz(1'b0, "private deactivate");
    vz(1'b1, "private deactivate");
    ev(8'h03, 1'b0);
    vz(1'b0, "unknown code");
    vz(1'b1, "unknown code");
    ev(8'h08, 1'b0);
    ev(8'h01, 1'b0);
    rd(8'h00, st(8'h08, 1'b1), "overflow");
    $display("test ignore and overflow done");
    apb(1'b0, 8'h24, 32'h0000_0000, r, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, r)
    apb(1'b0, 8'h05, 32'h0000_0000, r, e);
    `CHK("misaligned error", 1'b1, e)
    base_case(1'b0);
    base_case(1'b1);
    $display("test bus and bases done");
    results();
  end
endmodule
